// ---- design/pst_table_access.sv ----
// program counter addressing and table access path to program memory
// Summary of operation
// RQ1: program addresses are 24 bits, built from the 23-bit counter or from table page plus offset.
// RQ2: fetches stay in the lower half of program space; only table reads may reach configuration space.
// RQ3: each program location is a low word at an even address and a high word at an odd one, top byte absent.
// RQ4: the program counter steps by two per program word so addresses stay on the low word.
// RQ5: addresses from 0x000000 up to but not including 0x000200 hold fixed execution vectors, the reset vector among them.
// RQ6: the user image puts a jump at 0x000000 and its target at 0x000002; execution starts at that vector.
// RQ7: a word low table read returns program bits 15 to 0.
// RQ8: a byte low table read returns the high byte of the low word when byte select is one, else the low byte.
// RQ9: a word high table read returns program bits 23 to 16 with the upper data byte zero.
// RQ10: a byte high table read returns the selected upper byte in data bits 7 to 0, zero for the absent byte.
// RQ11: only the high table operations touch program bits 23 to 16; low ones touch bits 15 to 0 only.
// RQ12: every table operation works as byte or word, low and high spaces sharing one address range.
// RQ13: the program page of every table operation comes from the table page register.
// RQ14: page bit 7 clear maps table accesses to user space, set maps them to configuration space.
// RQ15: table reads are allowed with page bit 7 set so identification data can be read.
// RQ16: byte select is the least significant bit of the effective data address.
`timescale 1ns/1ns
`include "pst_defs.svh"

module pst_table_access (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic pc_load,
    input wire logic [`PST_PC_W-1:0] pc_load_addr,
    input wire logic pc_advance,
    output logic [`PST_ADDR_W-1:0] fetch_addr,
    output logic fetch_in_vectors,
    input wire logic page_wr,
    input wire logic [`PST_PAGE_W-1:0] page_wdata,
    output logic [`PST_PAGE_W-1:0] table_page_register,
    input wire logic tbl_req,
    input wire pst_pkg::pst_op_e tbl_op,
    input wire logic tbl_byte,
    input wire logic [`PST_DATA_W-1:0] tbl_ea,
    input wire logic [`PST_DATA_W-1:0] tbl_wdata,
    output logic tbl_ready,
    output logic [`PST_DATA_W-1:0] tbl_rdata,
    output logic tbl_rvalid,
    output logic tbl_wdone,
    output logic tbl_refused,
    output logic [`PST_ADDR_W-1:0] mem_addr,
    output logic mem_rd,
    output logic mem_wr,
    output logic [2:0] mem_be,
    output logic [`PST_ADDR_W-1:0] mem_wdata,
    input wire logic [`PST_ADDR_W-1:0] mem_rdata
);
    import pst_pkg::*;

    typedef struct packed {
        pst_state_e state;
        logic [`PST_PC_W-1:0] pc;
        logic [`PST_PAGE_W-1:0] page;
        logic [`PST_ADDR_W-1:0] addr;
        pst_op_e op;
        logic is_byte;
        logic bsel;
        logic rd;
        logic wr;
        logic [2:0] be;
        logic [`PST_ADDR_W-1:0] wdata;
        logic [`PST_DATA_W-1:0] rdata;
        logic rvalid;
        logic wdone;
        logic refused;
    } pst_state_s;

    pst_state_s st_q;
    pst_state_s st_d;
    logic take;
    logic is_write;
    logic [`PST_ADDR_W-1:0] req_addr;
    logic [`PST_DATA_W-1:0] rd_result;

    // a request is taken only while idle; the core must wait for ready
    assign tbl_ready = (st_q.state == PST_IDLE);
    assign take = tbl_req && tbl_ready;
    assign is_write = (tbl_op == PST_TABLE_WRITE_LOW) ||
                      (tbl_op == PST_TABLE_WRITE_HIGH);
    // page register supplies the top byte of every table address
    assign req_addr = {st_q.page, tbl_ea[`PST_DATA_W-1:1], 1'b0}; // [RQ1] [RQ13] [RQ3]

    // read data steering; upper data byte is always zero for high reads
    always_comb begin
        rd_result = `PST_ZERO_WORD;
        case (st_q.op)
            PST_TABLE_READ_LOW: begin
                if (!st_q.is_byte) begin
                    rd_result = mem_rdata[15:0]; // [RQ7] [RQ11]
                end else if (st_q.bsel) begin
                    rd_result = {`PST_ZERO_BYTE, mem_rdata[15:8]}; // [RQ8]
                end else begin
                    rd_result = {`PST_ZERO_BYTE, mem_rdata[7:0]}; // [RQ8]
                end
            end
            PST_TABLE_READ_HIGH: begin
                if (!st_q.is_byte || !st_q.bsel) begin
                    rd_result = {`PST_ZERO_BYTE, mem_rdata[23:16]}; // [RQ9] [RQ10]
                end else begin
                    rd_result = `PST_ZERO_WORD; // [RQ10] phantom byte
                end
            end
            default: begin
                rd_result = `PST_ZERO_WORD;
            end
        endcase
    end

    // next-state logic for counter, page and the table access sequence
    always_comb begin
        st_d = st_q;
        st_d.rvalid = 1'b0;
        st_d.wdone = 1'b0;
        st_d.refused = 1'b0;
        st_d.rd = 1'b0;
        st_d.wr = 1'b0;
        // jump wins over a plain step; bit 0 dropped to keep word alignment
        if (pc_load) begin
            st_d.pc = {pc_load_addr[`PST_PC_W-1:1], 1'b0}; // [RQ3]
        end else if (pc_advance) begin
            st_d.pc = st_q.pc + `PST_PC_STEP; // [RQ4]
        end
        if (page_wr) begin
            st_d.page = page_wdata; // [RQ13]
        end
        case (st_q.state)
            PST_IDLE: begin
                if (take) begin
                    st_d.addr = req_addr;
                    st_d.op = tbl_op;
                    st_d.is_byte = tbl_byte; // [RQ12]
                    st_d.bsel = tbl_ea[0]; // [RQ16]
                    // writes into configuration space are refused
                    if (is_write && st_q.page[`PST_PAGE_CFG_BIT]) begin
                        st_d.refused = 1'b1; // [RQ2] [RQ14]
                    end else if (is_write) begin
                        st_d.state = PST_WR_ISSUE;
                        st_d.wr = 1'b1;
                        st_d.be = `PST_BE_NONE;
                        st_d.wdata = `PST_ZERO_PROG;
                        if (tbl_op == PST_TABLE_WRITE_LOW) begin
                            st_d.wdata = {`PST_ZERO_BYTE, tbl_wdata}; // [RQ11]
                            if (!tbl_byte) begin
                                st_d.be = `PST_BE_LOW_WORD;
                            end else if (tbl_ea[0]) begin
                                st_d.be = `PST_BE_MID_LANE; // [RQ16]
                                st_d.wdata = {`PST_ZERO_BYTE,
                                              tbl_wdata[7:0], `PST_ZERO_BYTE};
                            end else begin
                                st_d.be = `PST_BE_LOW_LANE;
                            end
                        end else begin
                            // high write: only program bits 23..16 exist
                            st_d.wdata = {tbl_wdata[7:0], `PST_ZERO_WORD};
                            if (!tbl_byte || !tbl_ea[0]) begin
                                st_d.be = `PST_BE_HIGH_LANE; // [RQ11]
                            end
                        end
                    end else begin
                        // reads may reach configuration space for ids
                        st_d.state = PST_RD_ISSUE; // [RQ15] [RQ14]
                        st_d.rd = 1'b1;
                    end
                end
            end
            PST_RD_ISSUE: begin
                st_d.state = PST_RD_CAPT;
            end
            PST_RD_CAPT: begin
                st_d.rdata = rd_result;
                st_d.rvalid = 1'b1;
                st_d.state = PST_IDLE;
            end
            PST_WR_ISSUE: begin
                st_d.wdone = 1'b1;
                st_d.state = PST_IDLE;
            end
            default: begin
                st_d.state = PST_IDLE;
            end
        endcase
    end

    // single state register; reset starts execution at the reset vector
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
            st_q.state <= PST_IDLE;
            st_q.pc <= `PST_PC_RESET; // [RQ5] [RQ6]
            st_q.page <= `PST_PAGE_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    // top address bit held low so fetches never leave user space
    assign fetch_addr = {1'b0, st_q.pc}; // [RQ1] [RQ2]
    assign fetch_in_vectors = (fetch_addr < `PST_VEC_END); // [RQ5]
    assign table_page_register = st_q.page;
    assign tbl_rdata = st_q.rdata;
    assign tbl_rvalid = st_q.rvalid;
    assign tbl_wdone = st_q.wdone;
    assign tbl_refused = st_q.refused;
    assign mem_addr = st_q.addr;
    assign mem_rd = st_q.rd;
    assign mem_wr = st_q.wr;
    assign mem_be = st_q.be;
    assign mem_wdata = st_q.wdata;

    chk_fetch_user_half: assert property ( // [RQ2]
        @(posedge core_clk) disable iff (!rst_n)
        fetch_addr <= `PST_USER_TOP)
        else $error("fetch address left user space");

    chk_pc_step_two: assert property ( // [RQ4]
        @(posedge core_clk) disable iff (!rst_n)
        (pc_advance && !pc_load) |=>
            fetch_addr[22:0] == $past(fetch_addr[22:0]) + `PST_PC_STEP)
        else $error("program counter did not step by two");

    chk_fetch_even: assert property ( // [RQ3]
        @(posedge core_clk) disable iff (!rst_n)
        fetch_addr[0] == 1'b0)
        else $error("fetch address not on the low word");

    chk_page_in_addr: assert property ( // [RQ13]
        @(posedge core_clk) disable iff (!rst_n)
        take |=> mem_addr[23:16] == $past(st_q.page))
        else $error("table address page not from page register");

    chk_read_latency: assert property ( // [RQ15]
        @(posedge core_clk) disable iff (!rst_n)
        (take && !is_write) |=> mem_rd ##1 !mem_rd ##1 tbl_rvalid)
        else $error("table read did not answer in two cycles");

    chk_cfg_write_block: assert property ( // [RQ14]
        @(posedge core_clk) disable iff (!rst_n)
        (take && is_write && st_q.page[`PST_PAGE_CFG_BIT]) |=>
            tbl_refused && !mem_wr)
        else $error("configuration space write not refused");

    chk_high_read_zero: assert property ( // [RQ9]
        @(posedge core_clk) disable iff (!rst_n)
        (st_q.state == PST_RD_CAPT && st_q.op == PST_TABLE_READ_HIGH) |=>
            tbl_rdata[15:8] == `PST_ZERO_BYTE)
        else $error("high read upper data byte not zero");

    chk_low_word_read: assert property ( // [RQ7]
        @(posedge core_clk) disable iff (!rst_n)
        (st_q.state == PST_RD_CAPT && st_q.op == PST_TABLE_READ_LOW &&
         !st_q.is_byte) |=> tbl_rdata == $past(mem_rdata[15:0]))
        else $error("low word read data wrong");

    chk_low_write_lanes: assert property ( // [RQ11]
        @(posedge core_clk) disable iff (!rst_n)
        (mem_wr && st_q.op == PST_TABLE_WRITE_LOW) |-> !mem_be[2])
        else $error("low table write touched upper byte");

    chk_byte_select: assert property ( // [RQ16]
        @(posedge core_clk) disable iff (!rst_n)
        take |=> st_q.bsel == $past(tbl_ea[0]))
        else $error("byte select not from address bit 0");
endmodule

// ---- design/pst_defs.svh ----
// address, field and reset constants of the program space table access block
`ifndef PST_DEFS_SVH
`define PST_DEFS_SVH

`define PST_ADDR_W 24
`define PST_PC_W 23
`define PST_PAGE_W 8
`define PST_DATA_W 16
`define PST_PC_RESET 23'h00_0000
`define PST_PC_STEP 23'h00_0002
`define PST_VEC_END 24'h00_0200
`define PST_USER_TOP 24'h7F_FFFF
`define PST_PAGE_RESET 8'h00
`define PST_PAGE_CFG_BIT 7
`define PST_BE_NONE 3'h0
`define PST_BE_LOW_LANE 3'h1
`define PST_BE_MID_LANE 3'h2
`define PST_BE_LOW_WORD 3'h3
`define PST_BE_HIGH_LANE 3'h4
`define PST_ZERO_BYTE 8'h00
`define PST_ZERO_WORD 16'h0000
`define PST_ZERO_PROG 24'h00_0000

`endif

// ---- design/pst_pkg.sv ----
// types shared by the program space table access block
package pst_pkg;
    typedef enum logic [1:0] {
        PST_TABLE_READ_LOW,
        PST_TABLE_READ_HIGH,
        PST_TABLE_WRITE_LOW,
        PST_TABLE_WRITE_HIGH
    } pst_op_e;

    typedef enum logic [1:0] {
        PST_IDLE,
        PST_RD_ISSUE,
        PST_RD_CAPT,
        PST_WR_ISSUE
    } pst_state_e;
endpackage

// ---- dv/pst_prog_mem.sv ----
// program memory model that answers the table access port of the block
`timescale 1ns/1ns
module pst_prog_mem (
    input wire logic core_clk,
    input wire logic [23:0] mem_addr,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic [2:0] mem_be,
    input wire logic [23:0] mem_wdata,
    output logic [23:0] mem_rdata
);
    logic [23:0] store [int];
    logic [23:0] w;

    // untouched locations hold an address-derived pattern
    function automatic logic [23:0] word_at(input logic [23:0] a);
        if (store.exists(int'(a))) begin
            return store[int'(a)];
        end
        return {a[23:16] ^ a[8:1] ^ 8'hC3, a[15:0] ^ 16'h5A96};
    endfunction

    // image opens with a jump and its target, encodings arbitrary
    initial begin
        mem_rdata = 24'h00_0000;
        store[0] = 24'h04_0200;
        store[2] = 24'h00_0000;
    end

    // data valid the cycle after a strobe, scrambled otherwise so that
    // a late capture shows up as a wrong value
    always @(posedge core_clk) begin
        if (mem_rd) begin
            mem_rdata <= word_at(mem_addr);
        end else begin
            mem_rdata <= ~mem_rdata;
        end
        if (mem_wr) begin
            w = word_at(mem_addr);
            w[7:0] = mem_be[0] ? mem_wdata[7:0] : w[7:0];
            w[15:8] = mem_be[1] ? mem_wdata[15:8] : w[15:8];
            w[23:16] = mem_be[2] ? mem_wdata[23:16] : w[23:16];
            store[int'(mem_addr)] = w;
        end
    end
endmodule

// ---- dv/program_space_table_access_tb_top.sv ----
// self-checking bench for the program space table access block
`timescale 1ns/1ns
`include "pst_defs.svh"
module program_space_table_access_tb_top;
    import pst_pkg::*;
    logic core_clk, rst_n, pc_load, pc_advance, page_wr, tbl_req, tbl_byte;
    logic [22:0] pc_load_addr;
    logic [7:0] page_wdata, page_q, cur_pg;
    pst_op_e tbl_op;
    logic [15:0] tbl_ea, tbl_wdata, tbl_rdata, rd;
    logic tbl_ready, tbl_rvalid, tbl_wdone, tbl_refused, mem_rd, mem_wr;
    logic fetch_in_vectors, m_wr;
    logic [23:0] fetch_addr, mem_addr, mem_wdata, mem_rdata, m_addr, m_wd;
    logic [2:0] mem_be, m_be, fin;
    int err_count = 0;
    int n_checks = 0;
    int lat;

    pst_table_access dut_u (.core_clk(core_clk), .rst_n(rst_n),
        .pc_load(pc_load), .pc_load_addr(pc_load_addr),
        .pc_advance(pc_advance), .fetch_addr(fetch_addr),
        .fetch_in_vectors(fetch_in_vectors), .page_wr(page_wr),
        .page_wdata(page_wdata), .table_page_register(page_q),
        .tbl_req(tbl_req), .tbl_op(tbl_op), .tbl_byte(tbl_byte),
        .tbl_ea(tbl_ea), .tbl_wdata(tbl_wdata), .tbl_ready(tbl_ready),
        .tbl_rdata(tbl_rdata), .tbl_rvalid(tbl_rvalid),
        .tbl_wdone(tbl_wdone), .tbl_refused(tbl_refused),
        .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
        .mem_be(mem_be), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
    pst_prog_mem mem_u (.core_clk(core_clk), .mem_addr(mem_addr),
        .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_be(mem_be),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

    task automatic close_out();
        if (err_count == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [23:0] seen,
                       input logic [23:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // inputs always move one ns after the rising edge
    task automatic step();
        @(posedge core_clk);
        #1;
    endtask
    task automatic set_page(input logic [7:0] p);
        page_wr = 1'b1;
        page_wdata = p;
        cur_pg = p;
        step();
        page_wr = 1'b0;
        chk("page", {16'h0000, page_q}, {16'h0000, p});
    endtask
    // one table request; records the memory strobe and the answer
    task automatic tbl_go(input pst_op_e op, input logic b,
                          input logic [15:0] ea, input logic [15:0] wd);
        tbl_op = op;
        tbl_byte = b;
        tbl_ea = ea;
        tbl_wdata = wd;
        tbl_req = 1'b1;
        step();
        tbl_req = 1'b0;
        m_wr = 1'b0;
        for (lat = 0; lat < 6; lat++) begin
            if (mem_rd === 1'b1 || mem_wr === 1'b1) begin
                m_addr = mem_addr;
                m_be = mem_be;
                m_wd = mem_wdata;
                m_wr = mem_wr;
            end
            fin = {tbl_rvalid, tbl_wdone, tbl_refused};
            if (fin !== 3'b000) break;
            step();
        end
        rd = tbl_rdata;
        if (lat == 6) begin
            err_count++;
            close_out();
        end
    endtask
    task automatic rd_case(input pst_op_e op, input logic b,
                           input logic [15:0] ea);
        logic [23:0] a, w;
        logic [15:0] e;
        a = {cur_pg, ea[15:1], 1'b0};
        w = mem_u.word_at(a);
        if (op == PST_TABLE_READ_LOW) begin
            e = !b ? w[15:0] : {8'h00, ea[0] ? w[15:8] : w[7:0]};
        end else begin
            e = (b && ea[0]) ? 16'h0000 : {8'h00, w[23:16]};
        end
        tbl_go(op, b, ea, 16'h0000);
        chk("rd_addr", m_addr, a);
        chk("rd_lat", 24'(lat), 24'h00_0002);
        chk("rd_data", {8'h00, rd}, {8'h00, e});
    endtask
    task automatic wr_case(input pst_op_e op, input logic b,
                           input logic [15:0] ea, input logic [15:0] wd,
                           input logic [2:0] be, input logic [23:0] ed);
        logic [23:0] mk;
        mk = {{8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        tbl_go(op, b, ea, wd);
        chk("wr_be", {21'h0, m_be}, {21'h0, be});
        chk("wr_data", m_wd & mk, ed & mk);
        chk("wr_addr", m_addr, {cur_pg, ea[15:1], 1'b0});
    endtask

    // counter, reset vector and vector area flag
    task automatic t_fetch();
        chk("rst_pc", fetch_addr, 24'h00_0000);
        chk("rst_vec", {23'h0, fetch_in_vectors}, 24'h1);
        chk("rst_rdy", {23'h0, tbl_ready}, 24'h1);
        pc_advance = 1'b1;
        repeat (3) step();
        pc_advance = 1'b0;
        chk("pc_step", fetch_addr, 24'h00_0006);
        pc_load = 1'b1;
        pc_load_addr = 23'h00_01FF;
        step();
        pc_load = 1'b0;
        chk("pc_load", fetch_addr, 24'h00_01FE);
        chk("in_vec", {23'h0, fetch_in_vectors}, 24'h1);
        pc_advance = 1'b1;
        step();
        pc_advance = 1'b0;
        chk("out_vec", {23'h0, fetch_in_vectors}, 24'h0);
        pc_load = 1'b1;
        pc_load_addr = 23'h7F_FFFF;
        step();
        pc_load = 1'b0;
        chk("pc_top", fetch_addr, 24'h7F_FFFE);
    endtask
    // every read kind back to back, in user and configuration pages
    task automatic t_reads();
        pst_op_e op;
        for (int p = 0; p < 3; p++) begin
            set_page(p[0] ? 8'h80 : 8'h01);
            for (int k = 0; k < 8; k++) begin
                op = k[2] ? PST_TABLE_READ_HIGH : PST_TABLE_READ_LOW;
                rd_case(op, k[1], {15'h091A, k[0] & k[1]});
            end
        end
    endtask
    // lane writes, read back, and a refused configuration write
    task automatic t_writes();
        set_page(8'h01);
        wr_case(PST_TABLE_WRITE_LOW, 1'b0, 16'h0040, 16'hBEEF, 3'h3,
                24'h00_BEEF);
        wr_case(PST_TABLE_WRITE_HIGH, 1'b1, 16'h0040, 16'h0077, 3'h4,
                24'h77_0000);
        wr_case(PST_TABLE_WRITE_LOW, 1'b1, 16'h0043, 16'h00AB, 3'h2,
                24'h00_AB00);
        wr_case(PST_TABLE_WRITE_HIGH, 1'b1, 16'h0043, 16'h0055, 3'h0,
                24'h00_0000);
        rd_case(PST_TABLE_READ_LOW, 1'b0, 16'h0040);
        rd_case(PST_TABLE_READ_HIGH, 1'b0, 16'h0040);
        rd_case(PST_TABLE_READ_LOW, 1'b0, 16'h0042);
        set_page(8'h80);
        tbl_go(PST_TABLE_WRITE_LOW, 1'b0, 16'h0040, 16'h1234);
        chk("refused", {21'h0, fin}, 24'h1);
        chk("no_wr", {23'h0, m_wr}, 24'h0);
    endtask
    // reset in mid-run clears counter, page and read data, then the
    // jump at the reset vector reads back through the table path
    task automatic t_reset();
        rst_n = 1'b0;
        cur_pg = 8'h00;
        step();
        chk("rr_pc", fetch_addr, 24'h00_0000);
        chk("rr_page", {16'h0000, page_q}, 24'h00_0000);
        chk("rr_rdata", {8'h00, tbl_rdata}, 24'h00_0000);
        rst_n = 1'b1;
        step();
        chk("rr_rdy", {23'h0, tbl_ready}, 24'h1);
        rd_case(PST_TABLE_READ_LOW, 1'b0, 16'h0000);
        rd_case(PST_TABLE_READ_LOW, 1'b0, 16'h0002);
    endtask

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    initial begin
        {rst_n, pc_load, pc_advance, page_wr, tbl_req, tbl_byte} = 6'h00;
        pc_load_addr = 23'h00_0000;
        page_wdata = 8'h00;
        cur_pg = 8'h00;
        tbl_op = PST_TABLE_READ_LOW;
        tbl_ea = 16'h0000;
        tbl_wdata = 16'h0000;
        repeat (12) step();
        rst_n = 1'b1;
        step();
        t_fetch();
        t_reads();
        t_writes();
        t_reset();
        close_out();
    end
endmodule
